// file: common/vc_lookup_pkg.sv
// shared constants and types for the virtual connection lookup engine
// assumes one clock domain; sram region map and entry layouts are fixed here
package vc_lookup_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int AXI_AW = 8;
   localparam int SA_W = 20;
   localparam int SD_W = 40;
   localparam int KEY_W = 48;
   localparam int VC_W = 16;
   localparam int SEL_W = 6;
   localparam int TAG_W = 28;

   // ----------------------------------------------------------------
   // register indices and byte addresses (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_MASTER_CFG = 8'h01;
   localparam logic [7:0] IDX_RAM_ADDR = 8'h21;
   localparam logic [7:0] IDX_RAM_DATA_LO = 8'h22;
   localparam logic [7:0] IDX_RAM_DATA_HI = 8'h23;
   localparam logic [7:0] IDX_RAM_CMD = 8'h24;
   localparam logic [7:0] IDX_LKP_STATUS = 8'h25;
   localparam logic [7:0] ADDR_MASTER_CFG = {IDX_MASTER_CFG[5:0], 2'b00};
   localparam logic [7:0] ADDR_RAM_ADDR = {IDX_RAM_ADDR[5:0], 2'b00};
   localparam logic [7:0] ADDR_RAM_DATA_LO = {IDX_RAM_DATA_LO[5:0], 2'b00};
   localparam logic [7:0] ADDR_RAM_DATA_HI = {IDX_RAM_DATA_HI[5:0], 2'b00};
   localparam logic [7:0] ADDR_RAM_CMD = {IDX_RAM_CMD[5:0], 2'b00};
   localparam logic [7:0] ADDR_LKP_STATUS = {IDX_LKP_STATUS[5:0], 2'b00};

   // ----------------------------------------------------------------
   // register fields and reset values
   // ----------------------------------------------------------------
   localparam int CFG_STANDBY_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h01;
   localparam int CMD_GO_BIT = 0;
   localparam int CMD_READ_BIT = 1;
   localparam int CMD_BUSY_BIT = 0;
   localparam int STAT_HIT_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;

   // ----------------------------------------------------------------
   // sram regions (sram_region_select_bits) and entry layouts
   // ----------------------------------------------------------------
   localparam logic [3:0] REGION_PRI = 4'h1;
   localparam logic [3:0] REGION_SEC = 4'h2;
   localparam logic [3:0] REGION_VC = 4'h3;
   localparam int SEC_LEFT_VC_BIT = 39;
   localparam int SEC_RIGHT_VC_BIT = 38;
   localparam int SEC_SEL_LSB = 32;
   localparam int SEC_LEFT_LSB = 16;
   localparam int SEC_RIGHT_LSB = 0;
   localparam int REC_ACTIVE_BIT = 39;
   localparam logic [VC_W-1:0] NULL_PTR = 16'h0000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int HOST_ACC_MAX_NS = 800;
   localparam int HOST_ACC_MAX_CYC = HOST_ACC_MAX_NS / CLK_PERIOD_NS;
   localparam int SRAM_LAT = 1;
   localparam int SYNC_STAGES = 2;
   // strobe flop, then sram latency, then the two sync stages on the data pins
   localparam logic [2:0] ACC_CYC = 3'(1 + SRAM_LAT + SYNC_STAGES);

   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SA_W-1:0] addr;
      logic [SD_W-1:0] wdata;
      logic data_oe;
      logic we_n;
      logic ce_n;
   } sram_out_type;

   typedef struct packed {
      logic hit;
      logic [VC_W-1:0] vc_addr;
   } lookup_result_type;

   typedef enum logic {
      M_IDLE = 1'b0,
      M_BUSY = 1'b1
   } mem_state_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_PRI = 2'b01,
      PH_NODE = 2'b10,
      PH_REC = 2'b11
   } lk_phase_type;

endpackage

// file: rtl/vc_search_trie_lookup.sv
// search-tree lookup engine with axi4-lite registers and indirect sram access
// assumes a synchronous sram with one cycle read latency and a key source on MCLK_I
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module vc_search_trie_lookup
   import vc_lookup_pkg::*;
(
   input wire logic MCLK_I, // 20 MHz clock
   input wire logic RST_I, // async reset, active high
   input wire logic [AXI_AW-1:0] AXI_AWADDR_I, // write address
   input wire logic AXI_AWVALID_I, // write address valid
   output logic AXI_AWREADY_O, // write address ready
   input wire logic [31:0] AXI_WDATA_I, // write data
   input wire logic [3:0] AXI_WSTRB_I, // byte enables
   input wire logic AXI_WVALID_I, // write data valid
   output logic AXI_WREADY_O, // write data ready
   output logic [1:0] AXI_BRESP_O, // write response
   output logic AXI_BVALID_O, // write response valid
   input wire logic AXI_BREADY_I, // write response ready
   input wire logic [AXI_AW-1:0] AXI_ARADDR_I, // read address
   input wire logic AXI_ARVALID_I, // read address valid
   output logic AXI_ARREADY_O, // read address ready
   output logic [31:0] AXI_RDATA_O, // read data
   output logic [1:0] AXI_RRESP_O, // read response
   output logic AXI_RVALID_O, // read data valid
   input wire logic AXI_RREADY_I, // read data ready
   input wire logic LKP_REQ_I, // lookup request
   input wire logic [VC_W-1:0] LKP_PRI_I, // primary key, table index
   input wire logic [KEY_W-1:0] LKP_KEY_I, // secondary key
   output logic LKP_BUSY_O, // lookup in progress
   output logic LKP_DONE_O, // result pulse
   output lookup_result_type LKP_RES_O, // hit flag and vc address
   output sram_out_type SRAM_O, // sram address, data, strobes
   input wire logic [SD_W-1:0] SRAM_D_I // sram data pins
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [SD_W-1:0] sd_meta_reg, sd_sync_reg;
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
   logic [7:0] cfg_reg, cfg_next;
   logic [SA_W-1:0] ram_addr_reg, ram_addr_next;
   logic [SD_W-1:0] ram_data_reg, ram_data_next;
   logic host_go_reg, host_go_next, host_read_reg, host_read_next;
   mem_state_type mstate_reg, mstate_next;
   lk_phase_type phase_reg, phase_next;
   logic [2:0] cnt_reg, cnt_next;
   logic owner_host_reg, owner_host_next;
   logic host_pend_reg, host_pend_next, host_done_reg, host_done_next;
   logic [SD_W-1:0] host_rdata_reg, host_rdata_next;
   logic [SA_W-1:0] lk_addr_reg, lk_addr_next;
   logic [VC_W-1:0] lk_pri_reg, lk_pri_next;
   logic [KEY_W-1:0] lk_key_reg, lk_key_next;
   logic busy_reg, busy_next, done_reg, done_next;
   lookup_result_type res_reg, res_next;
   sram_out_type sram_reg, sram_next;

   // merge byte lanes of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // sram data pin synchroniser
   // ----------------------------------------------------------------
   // the data pins sit outside the clock domain, so two stages before use
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         sd_meta_reg <= '0;
         sd_sync_reg <= '0;
      end else begin
         sd_meta_reg <= SRAM_D_I;
         sd_sync_reg <= sd_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite slave and register file
   // ----------------------------------------------------------------
   // address and data are taken in either order; one write at a time
   always_comb begin
      logic [31:0] w;
      w = '0;
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next = w_hold_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      cfg_next = cfg_reg;
      ram_addr_next = ram_addr_reg;
      ram_data_next = ram_data_reg;
      host_go_next = 1'b0;
      host_read_next = host_read_reg;
      if (AXI_AWVALID_I && !aw_hold_reg && !bvalid_reg) begin
         aw_hold_next = 1'b1;
         aw_addr_next = AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && !w_hold_reg && !bvalid_reg) begin
         w_hold_next = 1'b1;
         wdata_next = AXI_WDATA_I;
         wstrb_next = AXI_WSTRB_I;
      end
      if (bvalid_reg && AXI_BREADY_I) begin
         bvalid_next = 1'b0;
      end
      // indirect read data returns from the engine
      if (host_done_reg && host_read_reg) begin
         ram_data_next = host_rdata_reg;
      end
      if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = AXI_OKAY;
         unique case (aw_addr_reg)
            ADDR_MASTER_CFG: begin
               w = merge({24'h000000, cfg_reg}, wdata_reg, wstrb_reg);
               cfg_next = w[7:0]; // standby gates lookups
            end
            ADDR_RAM_ADDR: begin
               w = merge({12'h000, ram_addr_reg}, wdata_reg, wstrb_reg);
               ram_addr_next = w[SA_W-1:0];
            end
            ADDR_RAM_DATA_LO: begin
               ram_data_next[31:0] = merge(ram_data_reg[31:0], wdata_reg, wstrb_reg);
            end
            ADDR_RAM_DATA_HI: begin
               w = merge({24'h000000, ram_data_reg[SD_W-1:32]}, wdata_reg, wstrb_reg);
               ram_data_next[SD_W-1:32] = w[7:0];
            end
            ADDR_RAM_CMD: begin
               // a command while one is pending is dropped; poll busy first
               if (wstrb_reg[0] && wdata_reg[CMD_GO_BIT] && !host_pend_reg && !(owner_host_reg && mstate_reg == M_BUSY)) begin
                  host_go_next = 1'b1;
                  host_read_next = wdata_reg[CMD_READ_BIT];
               end
            end
            default: begin
               bresp_next = AXI_SLVERR;
            end
         endcase
      end
      if (rvalid_reg && AXI_RREADY_I) begin
         rvalid_next = 1'b0;
      end
      if (AXI_ARVALID_I && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next = AXI_OKAY;
         rdata_next = '0;
         unique case (AXI_ARADDR_I)
            ADDR_MASTER_CFG: rdata_next[7:0] = cfg_reg;
            ADDR_RAM_ADDR: rdata_next[SA_W-1:0] = ram_addr_reg;
            ADDR_RAM_DATA_LO: rdata_next = ram_data_reg[31:0];
            ADDR_RAM_DATA_HI: rdata_next[7:0] = ram_data_reg[SD_W-1:32];
            ADDR_RAM_CMD: rdata_next[CMD_BUSY_BIT] = host_pend_reg | host_go_reg | (owner_host_reg & (mstate_reg == M_BUSY));
            ADDR_LKP_STATUS: begin
               rdata_next[VC_W-1:0] = res_reg.vc_addr;
               rdata_next[STAT_HIT_BIT] = res_reg.hit;
               rdata_next[STAT_BUSY_BIT] = busy_reg;
            end
            default: rresp_next = AXI_SLVERR;
         endcase
      end
      // readys registered from next state so the ports come from flops
      awready_next = !aw_hold_next && !bvalid_next;
      wready_next = !w_hold_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   // register the bus and register file state
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_hold_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg <= AXI_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= AXI_OKAY;
         rdata_reg <= '0;
         cfg_reg <= CFG_RESET; // async reset puts the engine in standby
         ram_addr_reg <= '0;
         ram_data_reg <= '0;
         host_go_reg <= 1'b0;
         host_read_reg <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         arready_reg <= 1'b1;
      end else begin
         aw_hold_reg <= aw_hold_next;
         aw_addr_reg <= aw_addr_next;
         w_hold_reg <= w_hold_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         cfg_reg <= cfg_next;
         ram_addr_reg <= ram_addr_next;
         ram_data_reg <= ram_data_next;
         host_go_reg <= host_go_next;
         host_read_reg <= host_read_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
      end
   end

   // ----------------------------------------------------------------
   // sram access sequencer and tree walk
   // ----------------------------------------------------------------
   // accesses are atomic and host requests win the next free slot, so a
   // host access waits at most one lookup access: bounded well under 16 cycles
   always_comb begin
      logic [VC_W-1:0] ptr;
      logic [SEL_W-1:0] sel;
      logic is_vc;
      logic key_bit;
      ptr = '0;
      sel = '0;
      is_vc = 1'b0;
      key_bit = 1'b0;
      mstate_next = mstate_reg;
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      owner_host_next = owner_host_reg;
      host_pend_next = host_pend_reg | host_go_reg;
      host_done_next = 1'b0;
      host_rdata_next = host_rdata_reg;
      lk_addr_next = lk_addr_reg;
      lk_pri_next = lk_pri_reg;
      lk_key_next = lk_key_reg;
      done_next = 1'b0;
      res_next = res_reg;
      sram_next = sram_reg;
      sram_next.we_n = 1'b1;
      sram_next.ce_n = 1'b1;
      sram_next.data_oe = 1'b0;
      // take a new lookup only when the walk is idle
      if (phase_reg == PH_IDLE && LKP_REQ_I && !busy_reg) begin
         lk_key_next = LKP_KEY_I;
         lk_pri_next = LKP_PRI_I;
         if (cfg_reg[CFG_STANDBY_BIT]) begin
            done_next = 1'b1; // standby: no tree is trusted, cell is dropped
            res_next = '0;
         end else begin
            phase_next = PH_PRI;
            lk_addr_next = {REGION_PRI, LKP_PRI_I};
         end
      end
      unique case (mstate_reg)
         M_IDLE: begin
            if (host_pend_reg) begin
               host_pend_next = host_go_reg; // a go in the same cycle wins over the clear
               owner_host_next = 1'b1;
               mstate_next = M_BUSY;
               cnt_next = ACC_CYC;
               sram_next.ce_n = 1'b0;
               sram_next.addr = ram_addr_reg;
               sram_next.wdata = ram_data_reg;
               sram_next.we_n = host_read_reg;
               sram_next.data_oe = !host_read_reg;
            end else if (phase_reg != PH_IDLE) begin
               owner_host_next = 1'b0;
               mstate_next = M_BUSY;
               cnt_next = ACC_CYC;
               sram_next.ce_n = 1'b0;
               sram_next.addr = lk_addr_reg;
            end
         end
         M_BUSY: begin
            cnt_next = cnt_reg - 3'h1;
            if (cnt_reg == 3'h1) begin
               mstate_next = M_IDLE;
               if (owner_host_reg) begin
                  host_done_next = 1'b1;
                  host_rdata_next = sd_sync_reg;
               end else begin
                  unique case (phase_reg)
                     PH_PRI: begin
                        ptr = sd_sync_reg[VC_W-1:0];
                        if (ptr == NULL_PTR) begin
                           phase_next = PH_IDLE; // empty tree is a miss
                           done_next = 1'b1;
                           res_next = '0;
                        end else begin
                           phase_next = PH_NODE;
                           lk_addr_next = {REGION_SEC, ptr};
                        end
                     end
                     PH_NODE: begin
                        sel = sd_sync_reg[SEC_SEL_LSB +: SEL_W];
                        // select 0 names the key msb; out of range reads as zero
                        if (sel <= SEL_W'(KEY_W - 1)) begin
                           key_bit = lk_key_reg[SEL_W'(KEY_W - 1) - sel];
                        end
                        if (key_bit) begin
                           ptr = sd_sync_reg[SEC_LEFT_LSB +: VC_W]; // one goes left
                           is_vc = sd_sync_reg[SEC_LEFT_VC_BIT];
                        end else begin
                           ptr = sd_sync_reg[SEC_RIGHT_LSB +: VC_W]; // zero goes right
                           is_vc = sd_sync_reg[SEC_RIGHT_VC_BIT];
                        end
                        phase_next = is_vc ? PH_REC : PH_NODE;
                        lk_addr_next = {(is_vc ? REGION_VC : REGION_SEC), ptr};
                     end
                     PH_REC: begin
                        // unlinked or inactive records never confirm
                        phase_next = PH_IDLE;
                        done_next = 1'b1;
                        res_next.hit = sd_sync_reg[REC_ACTIVE_BIT] && (sd_sync_reg[TAG_W-1:0] == lk_key_reg[TAG_W-1:0]);
                        res_next.vc_addr = res_next.hit ? lk_addr_reg[VC_W-1:0] : NULL_PTR;
                     end
                     default: begin
                        phase_next = PH_IDLE;
                     end
                  endcase
               end
            end
         end
      endcase
      busy_next = (phase_next != PH_IDLE);
   end

   // register the sequencer and walk state
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         mstate_reg <= M_IDLE;
         phase_reg <= PH_IDLE;
         cnt_reg <= '0;
         owner_host_reg <= 1'b0;
         host_pend_reg <= 1'b0;
         host_done_reg <= 1'b0;
         host_rdata_reg <= '0;
         lk_addr_reg <= '0;
         lk_pri_reg <= '0;
         lk_key_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         res_reg <= '0;
         sram_reg <= '{addr: '0, wdata: '0, data_oe: 1'b0, we_n: 1'b1, ce_n: 1'b1};
      end else begin
         mstate_reg <= mstate_next;
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         owner_host_reg <= owner_host_next;
         host_pend_reg <= host_pend_next;
         host_done_reg <= host_done_next;
         host_rdata_reg <= host_rdata_next;
         lk_addr_reg <= lk_addr_next;
         lk_pri_reg <= lk_pri_next;
         lk_key_reg <= lk_key_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         res_reg <= res_next;
         sram_reg <= sram_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flip-flops
   // ----------------------------------------------------------------
   assign AXI_AWREADY_O = awready_reg;
   assign AXI_WREADY_O = wready_reg;
   assign AXI_BVALID_O = bvalid_reg;
   assign AXI_BRESP_O = bresp_reg;
   assign AXI_ARREADY_O = arready_reg;
   assign AXI_RVALID_O = rvalid_reg;
   assign AXI_RDATA_O = rdata_reg;
   assign AXI_RRESP_O = rresp_reg;
   assign LKP_BUSY_O = busy_reg;
   assign LKP_DONE_O = done_reg;
   assign LKP_RES_O = res_reg;
   assign SRAM_O = sram_reg;

endmodule

`default_nettype wire

// file: test/vc_sram_model.sv
// sram partner: registered read one cycle after the strobe
// assumes the strobe struct of the package; unread cycles show inverted data
`timescale 1ns/1ps
`default_nettype none
module vc_sram_model
   import vc_lookup_pkg::*;
(
   input wire logic clk_i, // design clock
   input wire sram_out_type sram_i, // strobes from the design
   output logic [SD_W-1:0] d_o // data toward the design
);
   bit [SD_W-1:0] mem[bit [SA_W-1:0]];
   initial d_o = '0;
   // write on strobe; a stale bus flips so a late sample never matches
   always @(posedge clk_i) begin
      if (!sram_i.ce_n && !sram_i.we_n)
         mem[sram_i.addr] = sram_i.wdata;
      d_o <= (!sram_i.ce_n && sram_i.we_n) ? mem[sram_i.addr] : ~d_o;
   end
endmodule
`default_nettype wire

// file: test/vc_lookup_checker.sv
// port checker for the lookup engine
// assumes single clock MCLK_I and high-active RST_I
`timescale 1ns/1ps
`default_nettype none
module vc_lookup_checker
   import vc_lookup_pkg::*;
(
   input wire logic MCLK_I, RST_I, AXI_AWVALID_I, AXI_AWREADY_O, AXI_WVALID_I,
   input wire logic AXI_WREADY_O, AXI_BVALID_O, AXI_ARVALID_I, AXI_ARREADY_O,
   input wire logic AXI_RVALID_O, LKP_BUSY_O, LKP_DONE_O,
   input wire lookup_result_type LKP_RES_O,
   input wire sram_out_type SRAM_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   property p_done_pulse; LKP_DONE_O |=> !LKP_DONE_O; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_miss; LKP_DONE_O && !LKP_RES_O.hit |-> LKP_RES_O.vc_addr == NULL_PTR; endproperty
   a_miss: assert property (p_miss) else $error("miss with address");
   property p_done_idle; LKP_DONE_O |-> !LKP_BUSY_O; endproperty
   a_done_idle: assert property (p_done_idle) else $error("busy at done");
   property p_res_hold; !LKP_DONE_O |-> $stable(LKP_RES_O); endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved");
   property p_walk; $rose(LKP_BUSY_O) |-> ##[1:600] LKP_DONE_O; endproperty
   a_walk: assert property (p_walk) else $error("walk hung");
   property p_strobe; !SRAM_O.ce_n |=> SRAM_O.ce_n; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe wide");
   property p_bresp;
      AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O |-> ##[1:2] AXI_BVALID_O;
   endproperty
   a_bresp: assert property (p_bresp) else $error("no write response");
   property p_rresp; AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O; endproperty
   a_rresp: assert property (p_rresp) else $error("no read data");
   // main scenarios
   c_hit: cover property (LKP_DONE_O && LKP_RES_O.hit);
   c_miss: cover property (LKP_DONE_O && !LKP_RES_O.hit);
   c_wr: cover property (!SRAM_O.ce_n && !SRAM_O.we_n);
endmodule
bind vc_search_trie_lookup vc_lookup_checker u_vc_lookup_checker (.*);
`default_nettype wire

// file: test/tb_top.sv
// testbench: tree built through indirect sram writes, lookups against a model
// assumes the sram partner answers one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vc_lookup_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, req = 0, stby = 1;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, rs = 32'h06E966E4;
   logic [15:0] pri = 0;
   logic [47:0] key = 0, ka, kb;
   logic awr, wrd, bv, arr, rv, busy, done;
   logic [1:0] bresp, rresp;
   lookup_result_type res;
   sram_out_type so;
   logic [SD_W-1:0] sd;
   int mismatches = 0, check_count = 0, s;
   bit [39:0] m[bit [19:0]];
   vc_search_trie_lookup u_vc_search_trie_lookup (.MCLK_I(clk), .RST_I(rst),
      .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd),
      .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv), .AXI_WREADY_O(wrd), .AXI_BRESP_O(bresp),
      .AXI_BVALID_O(bv), .AXI_BREADY_I(br), .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv),
      .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv),
      .AXI_RREADY_I(rr), .LKP_REQ_I(req), .LKP_PRI_I(pri), .LKP_KEY_I(key),
      .LKP_BUSY_O(busy), .LKP_DONE_O(done), .LKP_RES_O(res), .SRAM_O(so), .SRAM_D_I(sd));
   vc_sram_model u_vc_sram_model (.clk_i(clk), .sram_i(so), .d_o(sd));
   initial forever #25 clk = ~clk;
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   // reference walk over the mirror of sram
   function automatic logic [16:0] walk(logic [15:0] p, logic [47:0] k);
      logic [39:0] e;
      logic [15:0] v;
      if (stby) return 17'h0;
      v = m[{REGION_PRI, p}][15:0];
      if (v == NULL_PTR) return 17'h0;
      for (int i = 0; i < 64; i++) begin
         e = m[{REGION_SEC, v}];
         v = k[47 - e[37:32]] ? e[31:16] : e[15:0];
         if (k[47 - e[37:32]] ? e[39] : e[38]) break;
      end
      e = m[{REGION_VC, v}];
      return (e[39] && e[27:0] == k[27:0]) ? {1'b1, v} : 17'h0;
   endfunction
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic summarize;
      if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (!bv);
      br <= 0;
      chk(bresp, AXI_OKAY);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rr <= 1;
      do begin
         @(posedge clk);
         if (arr) arv <= 0;
      end while (!rv);
      rr <= 0;
      d = rdat;
      chk(rresp, er);
   endtask
   // indirect write, then busy must be gone within the access bound
   task automatic ramw(input logic [19:0] a, input logic [39:0] v);
      logic [31:0] d;
      m[a] = v;
      wr(ADDR_RAM_ADDR, {12'h0, a});
      wr(ADDR_RAM_DATA_LO, v[31:0]);
      wr(ADDR_RAM_DATA_HI, {24'h0, v[39:32]});
      wr(ADDR_RAM_CMD, 32'h1);
      repeat (HOST_ACC_MAX_CYC - 4) @(posedge clk);
      rd(ADDR_RAM_CMD, d, AXI_OKAY);
      chk(d[CMD_BUSY_BIT], 0);
   endtask
   task automatic lk(input logic [15:0] p, input logic [47:0] k);
      logic [16:0] e;
      logic [31:0] d;
      e = walk(p, k);
      @(posedge clk);
      req <= 1;
      pri <= p;
      key <= k;
      do begin
         @(posedge clk);
         req <= 0;
      end while (!done);
      chk(res, e);
      rd(ADDR_LKP_STATUS, d, AXI_OKAY);
      chk(d[17:0], {1'b0, e});
   endtask
   initial begin
      #2000000 mismatches++;
      summarize;
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      repeat (4) @(posedge clk);
      rst <= 0;
      rd(ADDR_MASTER_CFG, d, AXI_OKAY);
      chk(d[7:0], CFG_RESET);
      rd(8'hFC, d, AXI_SLVERR);
      ka = {xs(), xs()};
      lk(1, ka);
      for (int p = 0; p < 4; p++) ramw({REGION_PRI, 16'(p)}, 0);
      ramw({REGION_VC, 16'h5}, 0);
      wr(ADDR_MASTER_CFG, 0);
      stby = 0;
      lk(1, ka);
      ramw({REGION_VC, 16'h5}, {12'h800, ka[27:0]});
      ramw({REGION_SEC, 16'h1}, {8'hC0, 16'h5, 16'h5});
      ramw({REGION_PRI, 16'h1}, 1);
      lk(1, ka);
      lk(1, ka ^ 1);
      wr(ADDR_RAM_ADDR, {12'h0, REGION_VC, 16'h5});
      wr(ADDR_RAM_CMD, 32'h3);
      repeat (HOST_ACC_MAX_CYC - 4) @(posedge clk);
      rd(ADDR_RAM_DATA_LO, d, AXI_OKAY);
      chk(d, m[{REGION_VC, 16'h5}][31:0]);
      rd(ADDR_RAM_DATA_HI, d, AXI_OKAY);
      chk(d, m[{REGION_VC, 16'h5}][39:32]);
      s = 20 + xs() % 28;
      kb = ka ^ (48'h1 << (47 - s));
      ramw({REGION_VC, 16'h6}, {12'h800, kb[27:0]});
      ramw({REGION_SEC, 16'h1}, {2'b11, 6'(s), kb[47-s] ? {16'h6, 16'h5} : {16'h5, 16'h6}});
      for (int i = 0; i < 24; i++) begin
         d = xs();
         lk({14'h0, d[2:1]}, {d[31:12], d[0] ? ka[27:0] : kb[27:0]});
      end
      ramw({REGION_SEC, 16'h1}, {8'hC0, 16'h5, 16'h5});
      lk(1, kb);
      ramw({REGION_VC, 16'h5}, 0);
      lk(1, ka);
      summarize;
   end
endmodule
`default_nettype wire
